// ==== shared/cmc_consts.vh ====
// Constants for the compatibility mode configuration logic.
`ifndef CMC_CONSTS_VH
`define CMC_CONSTS_VH

// Register addresses on the CPU bus.
`define CMC_ADDR_PORT_D_DIRECTION 16'h0007
`define CMC_ADDR_SERIAL_PERIPH_CONTROL 16'h000A
`define CMC_ADDR_WATCHDOG_SERVICE_A 16'h001D
`define CMC_ADDR_WATCHDOG_CONTROL_A 16'h001E
`define CMC_ADDR_SOFTWARE_OPTION 16'h3FDF
`define CMC_ADDR_WATCHDOG_CLEAR_B 16'h3FF0
`define CMC_ADDR_MODE_OPTION_NV 16'h3FF1

// Memory regions.
`define CMC_DUAL48_LO 16'h0020
`define CMC_DUAL48_HI 16'h004F
`define CMC_RAM_LO 16'h0050
`define CMC_RAM_HI 16'h00FF
`define CMC_DUAL128_LO 16'h0100
`define CMC_DUAL128_HI 16'h017F
`define CMC_GAP_LO 16'h0100
`define CMC_GAP_HI 16'h0FFF
`define CMC_EPROM_HI_LO 16'h1000
`define CMC_EPROM_HI_HI 16'h3EFF

// Memory sizes per mode, in bytes.
`define CMC_EPROM_BYTES_A 15932
`define CMC_RAM_BYTES_A 352
`define CMC_EPROM_BYTES_B 12092
`define CMC_RAM_BYTES_B 176

// Fields of mode_option_nv.
`define CMC_NV_MODE_BIT 0
`define CMC_NV_IRQ_BIT 1
`define CMC_NV_STOPDIS_BIT 2
`define CMC_NV_WDOG_EN_BIT 3
`define CMC_NV_SECURE_BIT 4
`define CMC_NV_MODE_A_MASK 8'hF1

// Fields of software_option.
`define CMC_SWO_IRQ_BIT 1
`define CMC_SWO_RAM1_BIT 6
`define CMC_SWO_RAM0_BIT 7
`define CMC_SWO_MASK 8'hC2

// Other fields.
`define CMC_SPC_OPEN_DRAIN_BIT 5
`define CMC_PD_MISO_BIT 2
`define CMC_PD_MOSI_BIT 3
`define CMC_PD_SCK_BIT 4

// Reset values.
`define CMC_RST_PORT_D_DIRECTION 7'h00
`define CMC_RST_SERIAL_PERIPH_CONTROL 8'h00
`define CMC_RST_WATCHDOG_CONTROL_A 8'h00
`define CMC_RST_SOFTWARE_OPTION 8'h02
`define CMC_MODE_A 1'b0
`define CMC_MODE_B 1'b1

`endif

// ==== src/cmc_config_logic.v ====
// Mode decode, register gating and pin gating for two emulation modes.
//
// Functional notes
// - Mode A: full map, both dual regions.
// - Mode B: 0x0100-0x0FFF disabled.
// - Mode A: 15932 EPROM, 352 RAM bytes.
// - Mode B: 12092 EPROM, 176 RAM bytes.
// - Option bits at 0x3FF1 act only in B, except the secure bit, which acts in both.
// - Software option register responds only in A.
// - Watchdog service/control registers only in A.
// - Write-only watchdog clear responds only in B.
// - Mode A: port D direction register enabled.
// - Mode B: port D input only.
// - Mode A: SPI outputs need direction bits.
// - Mode B: SPI outputs ignore direction bits.
// - Mode A: open-drain control bit honoured.
// - Mode B: open-drain control bit ignored.
// - Mode A: reset pin driven on faults.
// - Mode B: reset pin never driven.
// - Mode bit 1 selects B, 0 A.
// - Power-on reset forces mode A.
// - Mode A: B option bits read zero.
`timescale 1ns/1ps
`include "cmc_consts.vh"
module cmc_config_logic (
   // Clock, reset and enable.
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Nonvolatile option storage and power-on reset indication.
   input wire [7:0] nv_option_i,
   input wire por_i,
   // CPU register bus.
   input wire [15:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   // Memory region selects for the current address.
   output reg ram_sel_o,
   output reg eprom_sel_o,
   // Mode and option outputs.
   output reg mode_b_o,
   output reg irq_level_o,
   output reg stop_disable_o,
   output reg wdog_b_enable_o,
   output reg secure_o,
   output reg [7:0] wdog_a_control_o,
   output reg wdog_a_service_o,
   output reg wdog_b_clear_o,
   output reg [7:0] spi_control_o,
   // Watchdog and clock monitor timeouts.
   input wire wdog_timeout_i,
   input wire clkmon_timeout_i,
   // Port D and SPI pin gating.
   output reg [6:0] pd_dir_o,
   output reg pd_open_drain_o,
   input wire spi_mosi_drive_i,
   input wire spi_miso_drive_i,
   input wire spi_sck_drive_i,
   output reg spi_mosi_oe_o,
   output reg spi_miso_oe_o,
   output reg spi_sck_oe_o,
   // Open-drain reset pin.
   input wire reset_pin_i,
   output reg reset_pin_o,
   output reg reset_pin_oe_o
);
   wire [7:0] nv_sync;
   wire por_sync;
   wire reset_pin_sync;
   reg mode_b;
   reg mode_held;
   reg [1:0] settle;
   reg [6:0] port_d_direction;
   reg [7:0] serial_periph_control;
   reg [7:0] watchdog_control_a;
   reg [7:0] software_option;
   reg irq_written;
   reg hit_pdd;
   reg hit_spc;
   reg hit_wsa;
   reg hit_wca;
   reg hit_swo;
   reg hit_wcb;
   reg hit_mor;
   reg [7:0] next_rdata;
   reg next_ram_sel;
   reg next_eprom_sel;
   reg [7:0] mor_view;
   reg [6:0] pd_dir_eff;

   cmc_sync #(
      .WIDTH(8)
   ) u_nv_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i(nv_option_i),
      .sync_o(nv_sync)
   );

   cmc_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i({por_i, reset_pin_i}),
      .sync_o({por_sync, reset_pin_sync})
   );

   // Reset clears the synchroniser, so the stored byte shows at its output
   // only two enabled edges after release; catching the mode earlier would
   // always read mode A. It is caught then and held until reset or a power-on reset restarts the capture.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         mode_b <= `CMC_MODE_A;
         mode_held <= 1'b0;
         settle <= 2'h0;
      end else if (ce_i) begin
         if (por_sync) begin
            mode_b <= `CMC_MODE_A;
            mode_held <= 1'b0;
            settle <= 2'h0;
         end else if (settle != 2'h2) begin
            settle <= settle + 2'h1;
         end else if (!mode_held) begin
            mode_b <= nv_sync[`CMC_NV_MODE_BIT];
            mode_held <= 1'b1;
         end
      end
   end

   // Address hits; registers absent in the current mode never match.
   always @* begin
      hit_pdd = !mode_b && addr_i == `CMC_ADDR_PORT_D_DIRECTION;
      hit_spc = addr_i == `CMC_ADDR_SERIAL_PERIPH_CONTROL;
      hit_wsa = !mode_b && addr_i == `CMC_ADDR_WATCHDOG_SERVICE_A;
      hit_wca = !mode_b && addr_i == `CMC_ADDR_WATCHDOG_CONTROL_A;
      hit_swo = !mode_b && addr_i == `CMC_ADDR_SOFTWARE_OPTION;
      hit_wcb = mode_b && addr_i == `CMC_ADDR_WATCHDOG_CLEAR_B;
      hit_mor = addr_i == `CMC_ADDR_MODE_OPTION_NV;
   end

   // Option bits that only exist in mode B read as zero in mode A.
   always @* begin
      mor_view = nv_sync;
      if (!mode_b) begin
         mor_view = nv_sync & `CMC_NV_MODE_A_MASK;
      end
   end

   // Read data multiplexer; unmapped and disabled locations read zero.
   always @* begin
      next_rdata = 8'h00;
      if (hit_pdd) begin
         next_rdata = {1'b0, port_d_direction};
      end else if (hit_spc) begin
         next_rdata = serial_periph_control;
      end else if (hit_wca) begin
         next_rdata = watchdog_control_a;
      end else if (hit_swo) begin
         next_rdata = software_option;
      end else if (hit_mor) begin
         next_rdata = mor_view;
      end
   end

   // Memory decode. The EPROM totals of each mode also count vectors and
   // option locations outside the ranges decoded here.
   always @* begin
      next_ram_sel = 1'b0;
      next_eprom_sel = 1'b0;
      if (addr_i >= `CMC_RAM_LO && addr_i <= `CMC_RAM_HI) begin
         next_ram_sel = 1'b1;
      end else if (addr_i >= `CMC_DUAL48_LO
                   && addr_i <= `CMC_DUAL48_HI) begin
         if (!mode_b && software_option[`CMC_SWO_RAM0_BIT]) begin
            next_ram_sel = 1'b1;
         end else begin
            next_eprom_sel = 1'b1;
         end
      end else if (addr_i >= `CMC_GAP_LO && addr_i <= `CMC_GAP_HI) begin
         if (!mode_b) begin
            if (addr_i <= `CMC_DUAL128_HI
                && software_option[`CMC_SWO_RAM1_BIT]) begin
               next_ram_sel = 1'b1;
            end else begin
               next_eprom_sel = 1'b1;
            end
         end
         // In mode B this whole range answers to nothing.
      end else if (addr_i >= `CMC_EPROM_HI_LO
                   && addr_i <= `CMC_EPROM_HI_HI) begin
         next_eprom_sel = 1'b1;
      end
   end

   // Register writes; a write to a disabled location has no effect.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         port_d_direction <= `CMC_RST_PORT_D_DIRECTION;
         serial_periph_control <= `CMC_RST_SERIAL_PERIPH_CONTROL;
         watchdog_control_a <= `CMC_RST_WATCHDOG_CONTROL_A;
         software_option <= `CMC_RST_SOFTWARE_OPTION;
         irq_written <= 1'b0;
      end else if (ce_i && wr_i) begin
         if (hit_pdd) begin
            port_d_direction <= wdata_i[6:0];
         end
         if (hit_spc) begin
            serial_periph_control <= wdata_i;
         end
         if (hit_wca) begin
            watchdog_control_a <= wdata_i;
         end
         if (hit_swo) begin
            // The interrupt sense bit may be written only once.
            software_option[`CMC_SWO_RAM0_BIT] <=
               wdata_i[`CMC_SWO_RAM0_BIT];
            software_option[`CMC_SWO_RAM1_BIT] <=
               wdata_i[`CMC_SWO_RAM1_BIT];
            if (!irq_written) begin
               software_option[`CMC_SWO_IRQ_BIT] <=
                  wdata_i[`CMC_SWO_IRQ_BIT];
               irq_written <= 1'b1;
            end
         end
      end
   end

   // Effective direction bits: all inputs in mode B.
   always @* begin
      pd_dir_eff = port_d_direction;
      if (mode_b) begin
         pd_dir_eff = 7'h00;
      end
   end

   // Registered outputs.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         rdata_o <= 8'h00;
         ram_sel_o <= 1'b0;
         eprom_sel_o <= 1'b0;
         mode_b_o <= `CMC_MODE_A;
         irq_level_o <= 1'b0;
         stop_disable_o <= 1'b0;
         wdog_b_enable_o <= 1'b0;
         secure_o <= 1'b0;
         wdog_a_control_o <= `CMC_RST_WATCHDOG_CONTROL_A;
         wdog_a_service_o <= 1'b0;
         wdog_b_clear_o <= 1'b0;
         spi_control_o <= `CMC_RST_SERIAL_PERIPH_CONTROL;
         pd_dir_o <= 7'h00;
         pd_open_drain_o <= 1'b0;
         spi_mosi_oe_o <= 1'b0;
         spi_miso_oe_o <= 1'b0;
         spi_sck_oe_o <= 1'b0;
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
         ram_sel_o <= next_ram_sel;
         eprom_sel_o <= next_eprom_sel;
         mode_b_o <= mode_b;
         // Mode A takes interrupt sense from software, mode B from storage.
         if (mode_b) begin
            irq_level_o <= nv_sync[`CMC_NV_IRQ_BIT];
         end else begin
            irq_level_o <= software_option[`CMC_SWO_IRQ_BIT];
         end
         stop_disable_o <= mode_b
            && nv_sync[`CMC_NV_STOPDIS_BIT];
         wdog_b_enable_o <= mode_b
            && nv_sync[`CMC_NV_WDOG_EN_BIT];
         secure_o <= nv_sync[`CMC_NV_SECURE_BIT];
         wdog_a_control_o <= mode_b ? 8'h00 : watchdog_control_a;
         wdog_a_service_o <= wr_i && hit_wsa;
         wdog_b_clear_o <= wr_i && hit_wcb;
         spi_control_o <= serial_periph_control;
         pd_dir_o <= pd_dir_eff;
         pd_open_drain_o <= !mode_b
            && serial_periph_control[`CMC_SPC_OPEN_DRAIN_BIT];
         // SPI drive is gated by direction bits only in mode A.
         spi_mosi_oe_o <= spi_mosi_drive_i
            && (mode_b || port_d_direction[`CMC_PD_MOSI_BIT]);
         spi_miso_oe_o <= spi_miso_drive_i
            && (mode_b || port_d_direction[`CMC_PD_MISO_BIT]);
         spi_sck_oe_o <= spi_sck_drive_i
            && (mode_b || port_d_direction[`CMC_PD_SCK_BIT]);
         // Open drain: pulled low only, never driven high.
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= !mode_b && (por_sync || wdog_timeout_i
            || clkmon_timeout_i);
      end
   end

   // The synchronised pin level is kept for the reset controller; this
   // block only gates the drive.
   wire unused_reset_pin = reset_pin_sync;
endmodule // cmc_config_logic

// ==== src/cmc_sync.v ====
// Two flip-flop synchroniser for levels from outside the clock domain.
`timescale 1ns/1ps
module cmc_sync #(
   parameter WIDTH = 1
) (
   // Clock, reset and enable.
   input wire clk_i,
   input wire rst_b_i,
   input wire ce_i,
   // Data.
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] stage1;

   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         stage1 <= {WIDTH{1'b0}};
         sync_o <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule // cmc_sync

// ==== verif/cmc_config_checker.sv ====
// Assertion checker for the mode configuration logic.
`timescale 1ns/1ps
module cmc_config_checker (
   // Clock and reset.
   input wire clk_i,
   input wire rst_b_i,
   // Watched ports.
   input wire [15:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] nv_option_i,
   input wire [7:0] rdata_o,
   input wire mode_b_o,
   input wire stop_disable_o,
   input wire wdog_b_enable_o,
   input wire wdog_a_service_o,
   input wire wdog_b_clear_o,
   input wire [6:0] pd_dir_o,
   input wire pd_open_drain_o,
   input wire spi_mosi_drive_i,
   input wire spi_mosi_oe_o,
   input wire reset_pin_o,
   input wire reset_pin_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_clear_b_gate: assert property (
      wr_i && addr_i == 16'h3FF0 && mode_b_o |=> wdog_b_clear_o)
      else $error("clear pulse missing");
   a_clear_b_only: assert property (
      wdog_b_clear_o |-> $past(mode_b_o) && $past(wr_i))
      else $error("clear pulse out of mode");
   a_service_a_gate: assert property (
      wr_i && addr_i == 16'h001D && !mode_b_o |=> wdog_a_service_o)
      else $error("service pulse missing");
   a_service_a_only: assert property (
      wdog_a_service_o |-> !$past(mode_b_o))
      else $error("service pulse out of mode");
   a_dir_b_zero: assert property (mode_b_o |-> pd_dir_o == 7'h00)
      else $error("direction set in mode B");
   a_drain_b_off: assert property (mode_b_o |-> !pd_open_drain_o)
      else $error("open drain in mode B");
   a_pin_b_idle: assert property (
      mode_b_o |-> !reset_pin_oe_o && !reset_pin_o)
      else $error("reset pin driven in mode B");
   a_opts_a_zero: assert property (
      !mode_b_o |-> !stop_disable_o && !wdog_b_enable_o)
      else $error("mode B option active in mode A");
   a_spi_b_free: assert property (
      mode_b_o && spi_mosi_drive_i |=> spi_mosi_oe_o)
      else $error("data out enable missing in mode B");
   a_nv_read_a: assert property (
      rd_i && addr_i == 16'h3FF1 && !mode_b_o |=>
      rdata_o == ($past(nv_option_i, 3) & 8'hF1))
      else $error("option byte read unmasked");
endmodule // cmc_config_checker

bind cmc_config_logic cmc_config_checker chk (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
   .nv_option_i(nv_option_i), .rdata_o(rdata_o), .mode_b_o(mode_b_o),
   .stop_disable_o(stop_disable_o), .wdog_b_enable_o(wdog_b_enable_o),
   .wdog_a_service_o(wdog_a_service_o), .wdog_b_clear_o(wdog_b_clear_o),
   .pd_dir_o(pd_dir_o), .pd_open_drain_o(pd_open_drain_o),
   .spi_mosi_drive_i(spi_mosi_drive_i), .spi_mosi_oe_o(spi_mosi_oe_o),
   .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o));

// ==== verif/test_cmc_config_logic.sv ====
// Self-checking testbench for the mode configuration logic.
`timescale 1ns/1ps
module test_cmc_config_logic;
   logic clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic [7:0] nv_option_i = 8'h1E;
   logic por_i = 1'h0;
   logic [15:0] addr_i = 16'h0000;
   logic wr_i = 1'h0;
   logic rd_i = 1'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wdog_timeout_i = 1'h0;
   logic clkmon_timeout_i = 1'h0;
   logic [2:0] spi_drv = 3'h0;
   logic [7:0] rv;
   wire [7:0] rdata_o, wdog_a_control_o;
   wire [6:0] pd_dir_o;
   wire ram_sel_o, eprom_sel_o, mode_b_o, irq_level_o, stop_disable_o;
   wire wdog_b_enable_o, wdog_a_service_o, wdog_b_clear_o, pd_open_drain_o;
   wire spi_mosi_oe_o, spi_miso_oe_o, spi_sck_oe_o, reset_pin_o;
   wire reset_pin_oe_o;
   wire secure_o;
   wire [7:0] spi_control_o;
   wire [2:0] spi_oe = {spi_mosi_oe_o, spi_miso_oe_o, spi_sck_oe_o};
   wire [2:0] opts = {irq_level_o, stop_disable_o, wdog_b_enable_o};
   int num_errors = 0;
   int check_count = 0;

   always #5 clk_i = ~clk_i;

   // The clock enable and pin level stay fixed.
   cmc_config_logic uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'h1),
      .nv_option_i(nv_option_i), .por_i(por_i), .addr_i(addr_i),
      .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
      .ram_sel_o(ram_sel_o), .eprom_sel_o(eprom_sel_o),
      .mode_b_o(mode_b_o), .irq_level_o(irq_level_o),
      .stop_disable_o(stop_disable_o), .wdog_b_enable_o(wdog_b_enable_o),
      .secure_o(secure_o), .wdog_a_control_o(wdog_a_control_o),
      .wdog_a_service_o(wdog_a_service_o), .wdog_b_clear_o(wdog_b_clear_o),
      .spi_control_o(spi_control_o), .wdog_timeout_i(wdog_timeout_i),
      .clkmon_timeout_i(clkmon_timeout_i), .pd_dir_o(pd_dir_o),
      .pd_open_drain_o(pd_open_drain_o), .spi_mosi_drive_i(spi_drv[2]),
      .spi_miso_drive_i(spi_drv[1]), .spi_sck_drive_i(spi_drv[0]),
      .spi_mosi_oe_o(spi_mosi_oe_o), .spi_miso_oe_o(spi_miso_oe_o),
      .spi_sck_oe_o(spi_sck_oe_o), .reset_pin_i(1'h1),
      .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o));

   task check(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Option byte is first sampled on the edge after release; reset holds the synchroniser clear.
   task do_reset(input logic [7:0] nv, input logic por);
      @(negedge clk_i);
      rst_b_i = 1'h0;
      nv_option_i = nv;
      por_i = por;
      cyc(8);
      rst_b_i = 1'h1;
      cyc(4);
   endtask

   // Each access starts with an idle edge, so that two calls in a row never
   // lower and raise a strobe in the same time step.
   task wr(input logic [15:0] a, input logic [7:0] d);
      cyc(1);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'h1;
      cyc(1);
      wr_i = 1'h0;
   endtask

   task rd(input logic [15:0] a);
      cyc(1);
      addr_i = a;
      rd_i = 1'h1;
      cyc(1);
      rd_i = 1'h0;
      rv = rdata_o;
   endtask

   task probe(input logic [15:0] a);
      addr_i = a;
      cyc(1);
   endtask

   task test_mode_a;
      do_reset(8'h1E, 1'h0);
      check("mode", 8'(mode_b_o), 8'h00);
      check("stopdis", 8'(stop_disable_o), 8'h00);
      check("secure", 8'(secure_o), 8'h01);
      rd(16'h3FF1);
      check("nv", rv, 8'h10);
      wr(16'h001D, 8'h00);
      check("svc", 8'(wdog_a_service_o), 8'h01);
      wr(16'h3FF0, 8'h00);
      check("clr", 8'(wdog_b_clear_o), 8'h00);
      wr(16'h001E, 8'h5A);
      cyc(1);
      check("wctl", wdog_a_control_o, 8'h5A);
      wr(16'h3FDF, 8'hC0);
      wr(16'h3FDF, 8'hC2);
      rd(16'h3FDF);
      check("swo", rv, 8'hC0);
      check("irq", 8'(irq_level_o), 8'h00);
      wr(16'h0007, 8'h1C);
      cyc(1);
      check("dir", 8'(pd_dir_o), 8'h1C);
      spi_drv = 3'h7;
      cyc(2);
      check("oe", 8'(spi_oe), 8'h07);
      wr(16'h0007, 8'h00);
      cyc(2);
      check("oe", 8'(spi_oe), 8'h00);
      wr(16'h000A, 8'h20);
      cyc(1);
      check("odrain", 8'(pd_open_drain_o), 8'h01);
      check("spc", spi_control_o, 8'h20);
      probe(16'h0200);
      check("eprom", 8'(eprom_sel_o), 8'h01);
      probe(16'h0030);
      check("ram0", 8'(ram_sel_o), 8'h01);
      wdog_timeout_i = 1'h1;
      cyc(3);
      check("rstpin", 8'(reset_pin_oe_o), 8'h01);
      wdog_timeout_i = 1'h0;
      cyc(3);
      check("rstpin", 8'(reset_pin_oe_o), 8'h00);
      clkmon_timeout_i = 1'h1;
      cyc(3);
      check("rstpin", 8'(reset_pin_oe_o), 8'h01);
      clkmon_timeout_i = 1'h0;
      cyc(3);
      check("rstpin", 8'(reset_pin_oe_o), 8'h00);
      $display("test_mode_a done");
   endtask

   task test_por_mode;
      do_reset(8'h0F, 1'h1);
      check("mode", 8'(mode_b_o), 8'h00);
      check("rstpin", 8'(reset_pin_oe_o), 8'h01);
      por_i = 1'h0;
      cyc(6);
      check("mode", 8'(mode_b_o), 8'h01);
      check("rstpin", 8'(reset_pin_oe_o), 8'h00);
      $display("test_por_mode done");
   endtask

   task test_mode_b;
      check("opts", 8'(opts), 8'h07);
      wr(16'h3FF0, 8'h00);
      check("clr", 8'(wdog_b_clear_o), 8'h01);
      wr(16'h001D, 8'h00);
      check("svc", 8'(wdog_a_service_o), 8'h00);
      rd(16'h3FDF);
      check("swo", rv, 8'h00);
      rd(16'h001E);
      check("wctl", rv, 8'h00);
      wr(16'h0007, 8'h1C);
      rd(16'h0007);
      check("dirrd", rv, 8'h00);
      check("dir", 8'(pd_dir_o), 8'h00);
      check("oe", 8'(spi_oe), 8'h07);
      wr(16'h000A, 8'h20);
      cyc(1);
      check("odrain", 8'(pd_open_drain_o), 8'h00);
      probe(16'h0200);
      check("eprom", 8'(eprom_sel_o), 8'h00);
      wdog_timeout_i = 1'h1;
      cyc(3);
      check("rstpin", 8'(reset_pin_oe_o), 8'h00);
      $display("test_mode_b done");
   endtask

   initial begin
      test_mode_a();
      test_por_mode();
      test_mode_b();
      end_sim();
   end

   // The tests take under a hundred cycles; this leaves wide margin.
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
endmodule // test_cmc_config_logic
